//--- common/wckb_pkg.sv
// Constants for the wide classifier key builder: field widths, codes, offsets.
// Assumes a single clock domain shared with the frame parser and match stage.
package wckb_pkg;
    // Key subtype selector values
    localparam logic SUBTYPE_SEVEN = 1'h0;
    localparam logic SUBTYPE_PAYLOAD = 1'h1;
    // Generic index modes
    localparam logic [1:0] GIDX_DEFAULT = 2'h0;
    localparam logic [1:0] GIDX_COMPUTED = 2'h1;
    localparam logic [1:0] GIDX_SERVICE = 2'h2;
    localparam logic [1:0] GIDX_ROUTER = 2'h3;
    // Next-index control codes from the previous action
    localparam logic [1:0] NXT_NONE = 2'h0;
    localparam logic [1:0] NXT_VALUE = 2'h1;
    localparam logic [1:0] NXT_SERVICE = 2'h2;
    // Default generic index selection
    localparam logic [1:0] GDEF_ZERO = 2'h0;
    localparam logic [1:0] GDEF_LPORT = 2'h1;
    localparam logic [1:0] GDEF_MASQ = 2'h2;
    // Ingress mask modes
    localparam logic [1:0] MASK_DEFAULT = 2'h0;
    localparam logic [1:0] MASK_LOOPBACK = 2'h1;
    localparam logic [1:0] MASK_MASQ = 2'h2;
    localparam logic [1:0] MASK_PROC_VD = 2'h3;
    localparam logic [2:0] ACT_MASQ_INJ = 3'h1;
    // Source flag positions within the 5-bit source flags
    localparam int SRC_CPU0 = 0;
    localparam int SRC_CPU1 = 1;
    localparam int SRC_VD0 = 2;
    localparam int SRC_VD1 = 3;
    localparam int SRC_VD2 = 4;
    // Tag protocol identifiers and codes
    localparam logic [15:0] TPID_C = 16'h8100;
    localparam logic [15:0] TPID_S = 16'h88a8;
    localparam logic [2:0] TPC_NONE = 3'h0;
    localparam logic [2:0] TPC_C = 3'h1;
    localparam logic [2:0] TPC_S = 3'h4;
    localparam logic [2:0] TPC_CUST1 = 3'h5;
    localparam logic [2:0] TPC_CUST2 = 3'h6;
    localparam logic [2:0] TPC_CUST3 = 3'h7;
    // Frame type constants
    localparam logic [15:0] OVERLOADED_TYPE_FIELD_MIN = 16'h0600;
    localparam logic [15:0] OVERLOADED_TYPE_FIELD_IP4 = 16'h0800;
    localparam logic [15:0] OVERLOADED_TYPE_FIELD_IP6 = 16'h86dd;
    localparam logic [3:0] IPVER_4 = 4'h4;
    localparam logic [3:0] IPVER_6 = 4'h6;
    localparam logic [23:0] LLC_SNAP = 24'haaaa_03;
    localparam logic [3:0] IP4_MC_PFX = 4'he;
    localparam logic [7:0] IP6_MC_PFX = 8'hff;
    localparam logic [3:0] IHL_MIN = 4'h5;
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam int MAC_MC_BIT = 40;
    // Fragment types
    localparam logic [1:0] FRAG_NONE = 2'h0;
    localparam logic [1:0] FRAG_INITIAL = 2'h1;
    localparam logic [1:0] FRAG_SUSPECT = 2'h2;
    localparam logic [1:0] FRAG_FOLLOW = 2'h3;
    // Payload capture geometry, in bytes
    localparam int HEAD_BYTES = 128;
    localparam int PAYLOAD_BYTES = 64;
    localparam logic [6:0] ETH_BASE_LEN = 7'h0e;
    localparam logic [6:0] TAG_LEN = 7'h04;
    // Key widths
    localparam int MASK_W = 65;
    localparam int KEY_W = 553;
    localparam int PAYLOAD_KEY_W = 528;
endpackage

//--- hdl/wckb_top.sv
// Wide classifier key builder: forms the seven-tuple or payload search key.
// Assumes all inputs come from parser logic on MCLK and hold while KEY_REQ.
`timescale 1ns/10ps
`default_nettype none
module wckb_top
    import wckb_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_B,
    // Request
    input wire logic KEY_REQ,
    input wire logic KEY_PAYLOAD,
    input wire logic FIRST_LOOKUP,
    // Configuration
    input wire logic [1:0] GIDX_DEF_SEL,
    input wire logic MASQ_MASK_EN,
    input wire logic PROC_MASK_EN,
    input wire logic VD_MASK_EN,
    input wire logic USE_CL_OUTER_TAG,
    input wire logic USE_CL_DSCP,
    input wire logic [15:0] CUSTOM_TPID1,
    input wire logic [15:0] CUSTOM_TPID2,
    input wire logic [15:0] CUSTOM_TPID3,
    input wire logic [12:0] FRAG_OFFSET_THRES,
    input wire logic [15:0] MIN_L4_LEN,
    // Previous action and port context
    input wire logic PREV_ACT_VALID,
    input wire logic [1:0] NEXT_INDEX_CONTROL,
    input wire logic [11:0] NEXT_INDEX_VALUE,
    input wire logic [11:0] SERVICE_INDEX,
    input wire logic [11:0] ROUTER_LEG_INDEX,
    input wire logic [6:0] LOGICAL_PORT,
    input wire logic [6:0] PHYS_PORT,
    input wire logic [6:0] MASQ_PORT,
    input wire logic LOOPED,
    input wire logic [6:0] LOOP_PORT,
    input wire logic PROC_INJECTED,
    input wire logic [4:0] SRC_FLAGS,
    input wire logic [6:0] SRC_PORT,
    input wire logic [4:0] PIPELINE_POINT,
    input wire logic [2:0] PIPELINE_ACTION,
    input wire logic PERIODIC_INJ,
    // Layer 2
    input wire logic [47:0] DMAC,
    input wire logic [47:0] SMAC,
    input wire logic [1:0] TAG_COUNT,
    input wire logic [47:0] TAG_TPIDS,
    input wire logic [47:0] TAG_TCIS,
    input wire logic [15:0] CL_TCI,
    input wire logic [15:0] TYPE_LEN,
    input wire logic [23:0] LLC_HDR,
    input wire logic [39:0] SNAP_PID,
    // Layer 3 and 4
    input wire logic [3:0] IP_VERSION,
    input wire logic [3:0] IP_HDR_LEN,
    input wire logic [7:0] IP_PROTO,
    input wire logic [5:0] FRAME_DSCP,
    input wire logic [5:0] CL_DSCP,
    input wire logic [127:0] DIP,
    input wire logic [127:0] SIP,
    input wire logic MORE_FRAGS,
    input wire logic [12:0] FRAG_OFFSET,
    input wire logic [15:0] L4_LEN,
    input wire logic [15:0] SOURCE_PORT_FIELD_IN,
    input wire logic [15:0] L4_DPORT_IN,
    input wire logic OAM_FRAME,
    input wire logic [2:0] OAM_LEVEL,
    input wire logic [7:0] RANGE_MASK,
    // Payload source
    input wire logic FRAME_IS_ETH,
    input wire logic [6:0] FRAME_PTR,
    input wire logic [HEAD_BYTES*8-1:0] FRAME_HEAD,
    // Key output
    output logic KEY_VALID,
    output logic [KEY_W-1:0] KEY
);

    // Tag protocol value to its 3-bit code
    // First match wins, so a custom value equal to a standard one never shows
    function automatic logic [2:0] tpid_code(input logic [15:0] v);
        logic [2:0] c;
        c = TPC_NONE;
        if (v == TPID_C) begin
            c = TPC_C;
        end else if (v == TPID_S) begin
            c = TPC_S;
        end else if (v == CUSTOM_TPID1) begin
            c = TPC_CUST1;
        end else if (v == CUSTOM_TPID2) begin
            c = TPC_CUST2;
        end else if (v == CUSTOM_TPID3) begin
            c = TPC_CUST3;
        end
        return c;
    endfunction

    // One-hot bit in the ingress mask for a port number
    // Ports at 65 and above set no bit rather than wrapping
    function automatic logic [MASK_W-1:0] port_bit(input logic [6:0] p);
        logic [MASK_W-1:0] m;
        m = '0;
        if (p < 7'(MASK_W)) begin
            m[p] = 1'b1;
        end
        return m;
    endfunction

    logic [1:0] gsel;
    logic [11:0] gidx;
    logic [1:0] msel;
    logic [MASK_W-1:0] mask;
    logic [2:0] tags;
    logic [56:0] tag_fields;
    logic [15:0] tci0;
    logic layer2_multicast_flag, layer2_broadcast_flag, ip_multicast_flag, et_flag, ipsnap, ip4, ip6, tcpudp, tcp;
    logic l4_short, ip_opts;
    logic [15:0] otype;
    logic [1:0] frag;
    logic [5:0] dscp;
    logic [127:0] dip_f, sip_f;
    logic [15:0] sport;
    logic [6:0] pay_off;
    logic [PAYLOAD_BYTES*8-1:0] payload;
    logic [KEY_W-1:0] seven_key;
    logic [PAYLOAD_KEY_W-1:0] pay_key;
    logic [KEY_W-1:0] key_d;

    // generic index source
    // Third virtual device frames ignore the previous action, keyed on router leg
    // Control code 3 is unused and falls back to the default index
    always_comb begin
        gsel = GIDX_DEFAULT;
        gidx = '0;
        case (GIDX_DEF_SEL)
            GDEF_LPORT: gidx = {5'h00, LOGICAL_PORT};
            GDEF_MASQ: gidx = {5'h00, MASQ_PORT};
            default: gidx = '0;
        endcase
        if (SRC_FLAGS[SRC_VD2]) begin
            gsel = GIDX_ROUTER;
            gidx = ROUTER_LEG_INDEX;
        end else if (PREV_ACT_VALID && NEXT_INDEX_CONTROL == NXT_SERVICE) begin
            gsel = GIDX_SERVICE;
            gidx = SERVICE_INDEX;
        end else if (PREV_ACT_VALID && NEXT_INDEX_CONTROL == NXT_VALUE) begin
            gsel = GIDX_COMPUTED;
            gidx = NEXT_INDEX_VALUE;
        end
    end

    // highest mode wins
    // Checked top down so a frame meeting several criteria takes the highest
    always_comb begin
        msel = MASK_DEFAULT;
        mask = port_bit(PHYS_PORT);
        if ((PROC_INJECTED && PROC_MASK_EN) ||
            ((SRC_FLAGS[SRC_VD0] || SRC_FLAGS[SRC_VD1]) && VD_MASK_EN)) begin
            msel = MASK_PROC_VD;
            mask = {44'h000_0000_0000, PERIODIC_INJ, PIPELINE_ACTION,
                    PIPELINE_POINT, SRC_PORT, SRC_FLAGS};
        end else if (MASQ_MASK_EN && PIPELINE_ACTION == ACT_MASQ_INJ) begin
            msel = MASK_MASQ;
            mask = port_bit(MASQ_PORT);
        end else if (LOOPED) begin
            msel = MASK_LOOPBACK;
            mask = port_bit(LOOP_PORT);
        end
    end

    // MAC address flags
    // Broadcast sets the multicast flag too, since bit 40 is one
    assign layer2_multicast_flag = DMAC[MAC_MC_BIT];
    assign layer2_broadcast_flag = &DMAC;

    assign tags = {TAG_COUNT == 2'h3, TAG_COUNT >= 2'h2, TAG_COUNT != 2'h0};

    // outer tag source; VID forced to zero when untagged unless CL_TCI is selected
    assign tci0 = USE_CL_OUTER_TAG ? CL_TCI : (tags[0] ? TAG_TCIS[15:0] : 16'h0000);
    assign dscp = USE_CL_DSCP ? CL_DSCP : FRAME_DSCP;

    // per-tag protocol codes, absent tags coded zero
    // Absent inner tags are cleared so stale parser words never match
    always_comb begin
        tag_fields = '0;
        for (int i = 0; i < 3; i++) begin
            logic [15:0] tci;
            logic [2:0] code;
            tci = (i == 0) ? tci0 : TAG_TCIS[i*16 +: 16];
            code = tags[i] ? tpid_code(TAG_TPIDS[i*16 +: 16]) : TPC_NONE;
            if (!tags[i] && i > 0) begin
                tci = 16'h0000;
            end
            tag_fields[i*19 +: 19] = {tci[11:0], tci[12], tci[15:13], code};
        end
    end

    assign et_flag = TYPE_LEN >= OVERLOADED_TYPE_FIELD_MIN;
    assign ip4 = et_flag && TYPE_LEN == OVERLOADED_TYPE_FIELD_IP4 && IP_VERSION == IPVER_4;
    assign ip6 = et_flag && TYPE_LEN == OVERLOADED_TYPE_FIELD_IP6 && IP_VERSION == IPVER_6;
    assign ipsnap = ip4 || ip6 || (!et_flag && LLC_HDR == LLC_SNAP);

    assign tcp = (ip4 || ip6) && IP_PROTO == PROTO_TCP;
    assign tcpudp = tcp || ((ip4 || ip6) && IP_PROTO == PROTO_UDP) || OAM_FRAME;

    // IP multicast prefixes
    // Judged only for IP frames; all others leave the flag clear
    assign ip_multicast_flag = (ip4 && DIP[31:28] == IP4_MC_PFX) || (ip6 && DIP[127:120] == IP6_MC_PFX);

    // IPv4 addresses sit in the low word
    // Upper 96 bits cleared for IPv4 so stale parser bytes never match
    assign dip_f = ip4 ? {96'h0, DIP[31:0]} : DIP;
    assign sip_f = ip4 ? {96'h0, SIP[31:0]} : SIP;

    always_comb begin
        if (!et_flag && !ipsnap) begin
            otype = LLC_HDR[23:8];
        end else if (!et_flag) begin
            otype = SNAP_PID[39:24];
        end else if (ipsnap && tcpudp) begin
            otype = L4_DPORT_IN;
        end else if (ipsnap) begin
            otype = {8'h00, IP_PROTO};
        end else begin
            otype = TYPE_LEN;
        end
    end

    // fragment classification
    // An offset equal to the threshold still counts as suspicious
    always_comb begin
        if (FRAG_OFFSET == 13'h0000) begin
            frag = MORE_FRAGS ? FRAG_INITIAL : FRAG_NONE;
        end else if (FRAG_OFFSET <= FRAG_OFFSET_THRES) begin
            frag = FRAG_SUSPECT;
        end else begin
            frag = FRAG_FOLLOW;
        end
    end

    // OAM level thermometer
    // Level 7 fills bits 6:0; the upper bits stay clear
    always_comb begin
        sport = SOURCE_PORT_FIELD_IN;
        if (OAM_FRAME) begin
            sport = '0;
            for (int i = 0; i < 7; i++) begin
                sport[i] = (OAM_LEVEL > 3'(i));
            end
        end
    end

    // payload start and byte select
    // Offsets past the head window wrap; parser keeps pointer within range
    assign pay_off = FRAME_IS_ETH ? 7'(ETH_BASE_LEN + TAG_LEN * {5'h00, TAG_COUNT})
                                  : FRAME_PTR;
    always_comb begin
        payload = '0;
        for (int b = 0; b < PAYLOAD_BYTES; b++) begin
            logic [6:0] idx;
            idx = 7'(pay_off + 7'(b));
            payload[b*8 +: 8] = FRAME_HEAD[idx*8 +: 8];
        end
    end

    // short L4 length
    // Only flagged; the key still carries the segment's own fields
    assign l4_short = L4_LEN < MIN_L4_LEN;

    // IPv4 options present
    // Option bytes are never parsed, only their presence is keyed
    assign ip_opts = ip4 && IP_HDR_LEN > IHL_MIN;

    // contiguous packing, lowest field at bit 0
    // Widths sum to KEY_W; moving a field moves every field above it
    // subtype in bit 0
    assign seven_key = {RANGE_MASK, sport, tcp, tcpudp, // Transport
                        sip_f, dip_f, dscp, // Addresses and DSCP
                        ip_opts, l4_short, frag, // Fragment and length flags
                        ip4, ipsnap, otype, et_flag, ip_multicast_flag, // Frame type
                        SMAC, DMAC, tag_fields, tags, layer2_broadcast_flag, layer2_multicast_flag, // Layer 2
                        mask, msel, gidx, gsel, // Port mask and generic index
                        FIRST_LOOKUP, SUBTYPE_SEVEN}; // Lookup header
    // Top bits of a payload key stay zero so both formats share one width
    assign pay_key = {payload, gidx, gsel, FIRST_LOOKUP, SUBTYPE_PAYLOAD};
    assign key_d = KEY_PAYLOAD ? {25'h000_0000, pay_key} : seven_key;

    // Key register, loaded on request and held until the next one
    // Registered so the match array sees a steady word, at one cycle of latency
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            KEY <= '0;
        end else if (KEY_REQ) begin
            KEY <= key_d;
        end
    end

    // One-cycle strobe marking a fresh key
    // No back-pressure: a request every cycle gives a strobe every cycle
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            KEY_VALID <= 1'b0;
        end else begin
            KEY_VALID <= KEY_REQ;
        end
    end

endmodule
`default_nettype wire

//--- tb/wckb_props.sv
// Checker for the key builder: answer timing, flags and codes at the ports.
// Assumes it is bound onto wckb_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module wckb_props
    import wckb_pkg::*;
(
    // Clock, reset and request
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic KEY_REQ,
    input wire logic KEY_PAYLOAD,
    input wire logic FIRST_LOOKUP,
    // Frame fields
    input wire logic [1:0] TAG_COUNT,
    input wire logic [47:0] DMAC,
    input wire logic [15:0] TYPE_LEN,
    input wire logic [3:0] IP_VERSION,
    input wire logic [3:0] IP_HDR_LEN,
    input wire logic [15:0] L4_LEN,
    input wire logic [15:0] MIN_L4_LEN,
    input wire logic OAM_FRAME,
    input wire logic [2:0] OAM_LEVEL,
    // Key output
    input wire logic KEY_VALID,
    input wire logic [KEY_W-1:0] KEY
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    // Seven-tuple request, and one carrying an OAM frame
    sequence s_take7;
        KEY_REQ && !KEY_PAYLOAD;
    endsequence
    sequence s_oam;
        s_take7 ##0 OAM_FRAME;
    endsequence
    property p_answer;
        KEY_REQ |=> KEY_VALID && KEY[0] == $past(KEY_PAYLOAD) && KEY[1] == $past(FIRST_LOOKUP);
    endproperty
    a_answer: assert property (p_answer) else $error("key answer wrong");
    property p_idle;
        !KEY_REQ |=> !KEY_VALID && $stable(KEY);
    endproperty
    a_idle: assert property (p_idle) else $error("key moved without request");
    property p_l2;
        s_take7 |=> KEY[83] == $past(DMAC[MAC_MC_BIT]) && KEY[84] == &$past(DMAC);
    endproperty
    a_l2: assert property (p_l2) else $error("mac flags wrong");
    property p_tags;
        s_take7 |=> KEY[87:85] == (3'h1 << $past(TAG_COUNT)) - 3'h1;
    endproperty
    a_tags: assert property (p_tags) else $error("tag count code wrong");
    property p_overloaded_type_field;
        s_take7 |=> KEY[242] == ($past(TYPE_LEN) >= OVERLOADED_TYPE_FIELD_MIN);
    endproperty
    a_overloaded_type_field: assert property (p_overloaded_type_field) else $error("ethertype flag wrong");
    property p_l4len;
        s_take7 |=> KEY[263] == ($past(L4_LEN) < $past(MIN_L4_LEN));
    endproperty
    a_l4len: assert property (p_l4len) else $error("l4 length flag wrong");
    property p_opts;
        s_take7 ##0 (TYPE_LEN == OVERLOADED_TYPE_FIELD_IP4 && IP_VERSION == IPVER_4)
            |=> KEY[264] == ($past(IP_HDR_LEN) > IHL_MIN);
    endproperty
    a_opts: assert property (p_opts) else $error("options flag wrong");
    property p_oam;
        s_oam |=> KEY[527] && KEY[544:529] == (16'h0001 << $past(OAM_LEVEL)) - 16'h0001;
    endproperty
    a_oam: assert property (p_oam) else $error("oam level code wrong");
    property p_pay;
        KEY_REQ && KEY_PAYLOAD |=> KEY[552:528] == '0;
    endproperty
    a_pay: assert property (p_pay) else $error("payload key top not zero");
endmodule
bind wckb_top wckb_props u_props (.*);
`default_nettype wire

//--- tb/wckb_match_model.sv
// Match-stage stand-in: consumes each key and counts them.
// Assumes keys arrive as one-cycle valid pulses on the same clock.
`timescale 1ns/10ps
`default_nettype none
module wckb_match_model
    import wckb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Key from the builder
    input wire logic key_valid,
    input wire logic [KEY_W-1:0] key,
    // Consumed keys
    output logic [15:0] hits_q,
    output logic [KEY_W-1:0] last_key_q
);
    // Takes every key at once; the real array never stalls the builder
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hits_q <= 16'h0000;
            last_key_q <= '0;
        end else if (key_valid) begin
            hits_q <= hits_q + 16'h0001;
            last_key_q <= key;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Random self-checking bench for the key builder, expectations in a queue.
// Assumes the checker is bound in and the match model sits on the key.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import wckb_pkg::*;
    typedef struct packed {logic [KEY_W-1:0] e; logic [KEY_W-1:0] c;} wckb_note_t;
    logic MCLK, RST_B, KEY_REQ, KEY_PAYLOAD, FIRST_LOOKUP, MASQ_MASK_EN, PROC_MASK_EN;
    logic VD_MASK_EN, USE_CL_OUTER_TAG, USE_CL_DSCP, PREV_ACT_VALID, LOOPED, PROC_INJECTED;
    logic PERIODIC_INJ, MORE_FRAGS, OAM_FRAME, FRAME_IS_ETH, KEY_VALID;
    logic [1:0] GIDX_DEF_SEL, NEXT_INDEX_CONTROL, TAG_COUNT;
    logic [15:0] CUSTOM_TPID1, CUSTOM_TPID2, CUSTOM_TPID3, MIN_L4_LEN, CL_TCI, TYPE_LEN;
    logic [15:0] L4_LEN, SOURCE_PORT_FIELD_IN, L4_DPORT_IN, hits;
    logic [12:0] FRAG_OFFSET_THRES, FRAG_OFFSET;
    logic [11:0] NEXT_INDEX_VALUE, SERVICE_INDEX, ROUTER_LEG_INDEX;
    logic [6:0] LOGICAL_PORT, PHYS_PORT, MASQ_PORT, LOOP_PORT, SRC_PORT, FRAME_PTR;
    logic [4:0] SRC_FLAGS, PIPELINE_POINT;
    logic [2:0] PIPELINE_ACTION, OAM_LEVEL;
    logic [47:0] DMAC, SMAC, TAG_TPIDS, TAG_TCIS;
    logic [23:0] LLC_HDR;
    logic [39:0] SNAP_PID;
    logic [3:0] IP_VERSION, IP_HDR_LEN;
    logic [7:0] IP_PROTO, RANGE_MASK;
    logic [5:0] FRAME_DSCP, CL_DSCP;
    logic [127:0] DIP, SIP;
    logic [HEAD_BYTES*8-1:0] FRAME_HEAD;
    logic [KEY_W-1:0] KEY, e, c;
    wckb_note_t exp_q[$];
    wckb_note_t got;
    int seed = 87;
    int err_count = 0;
    int samples_checked = 0;
    int nreq = 0;
    int cyc = 0;
    logic [15:0] tl[4] = '{OVERLOADED_TYPE_FIELD_IP4, OVERLOADED_TYPE_FIELD_IP6, 16'h0040, 16'h88f5};
    logic [15:0] tp[8] = '{TPID_C, TPID_S, 16'h9100, 16'h9200, 16'h9300, 16'h5555,
        16'h0800, 16'hffff};

    wckb_top uut (.*);
    wckb_match_model u_match (.clk(MCLK), .rst_b(RST_B), .key_valid(KEY_VALID), .key(KEY),
        .hits_q(hits), .last_key_q());

    task automatic chk(string nm, logic [KEY_W-1:0] seen, logic [KEY_W-1:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, want, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic put(int lo, int w, logic [255:0] v);
        for (int i = 0; i < w; i++) begin
            e[lo + i] = v[i];
            c[lo + i] = 1'b1;
        end
    endtask

    function automatic logic [2:0] tpc(logic [15:0] v);
        return v == TPID_C ? TPC_C : v == TPID_S ? TPC_S : v == CUSTOM_TPID1 ? TPC_CUST1 :
            v == CUSTOM_TPID2 ? TPC_CUST2 : v == CUSTOM_TPID3 ? TPC_CUST3 : TPC_NONE;
    endfunction

    function automatic logic [15:0] tci(logic [15:0] t);
        return {t[11:0], t[12], t[15:13]};
    endfunction

    // Random frame and context; offsets straddle the fragment threshold
    task automatic drive(logic req);
        logic [1023:0] w;
        logic [31:0] r;
        logic [12:0] th;
        for (int i = 0; i < 32; i++) w[32 * i +: 32] = $random(seed);
        r = $random(seed);
        th = w[700:688];
        KEY_REQ <= req;
        {KEY_PAYLOAD, FIRST_LOOKUP, GIDX_DEF_SEL, MASQ_MASK_EN, PROC_MASK_EN} <= r[5:0];
        {VD_MASK_EN, USE_CL_OUTER_TAG, USE_CL_DSCP, PREV_ACT_VALID} <= r[9:6];
        NEXT_INDEX_CONTROL <= r[11:10] == 2'h3 ? NXT_NONE : r[11:10];
        {LOOPED, PROC_INJECTED, PERIODIC_INJ, MORE_FRAGS, FRAME_IS_ETH, TAG_COUNT} <= r[18:12];
        TYPE_LEN <= tl[r[20:19]];
        IP_VERSION <= r[21] ? IPVER_6 : IPVER_4;
        LLC_HDR <= r[22] ? LLC_SNAP : w[723:700];
        IP_PROTO <= r[23] ? PROTO_TCP : r[24] ? PROTO_UDP : w[731:724];
        OAM_FRAME <= r[20:19] == 2'h3 && r[25];
        FRAG_OFFSET_THRES <= th;
        FRAG_OFFSET <= r[27:26] == 2'h0 ? 13'h0000 : th + r[27:26] - 13'h0002;
        DMAC <= r[28] ? 48'hffff_ffff_ffff : w[399:352];
        for (int i = 0; i < 3; i++) TAG_TPIDS[16 * i +: 16] <= tp[w[640 + 3 * i +: 3]];
        FRAME_HEAD <= w;
        {DIP, SIP} <= w[255:0];
        {SMAC, TAG_TCIS} <= w[351:256];
        {SERVICE_INDEX, ROUTER_LEG_INDEX, NEXT_INDEX_VALUE} <= w[435:400];
        {LOGICAL_PORT, PHYS_PORT, MASQ_PORT, LOOP_PORT, SRC_PORT, FRAME_PTR} <= w[477:436];
        {SRC_FLAGS, PIPELINE_POINT, PIPELINE_ACTION, OAM_LEVEL} <= w[493:478];
        {CL_TCI, MIN_L4_LEN, L4_LEN, SOURCE_PORT_FIELD_IN, L4_DPORT_IN} <= w[573:494];
        {IP_HDR_LEN, RANGE_MASK, FRAME_DSCP, CL_DSCP, SNAP_PID} <= w[637:574];
    endtask

    // Expected key from the settled inputs; c marks the bits that are judged
    task automatic note();
        logic is4, is6, ip, tu;
        logic [7:0] st;
        logic [15:0] t0;
        is4 = TYPE_LEN == OVERLOADED_TYPE_FIELD_IP4 && IP_VERSION == IPVER_4;
        is6 = TYPE_LEN == OVERLOADED_TYPE_FIELD_IP6 && IP_VERSION == IPVER_6;
        ip = is4 || is6;
        tu = ip && (IP_PROTO == PROTO_TCP || IP_PROTO == PROTO_UDP);
        e = '0;
        c = '0;
        put(0, 2, {FIRST_LOOKUP, KEY_PAYLOAD});
        if (SRC_FLAGS[SRC_VD2]) put(2, 14, {ROUTER_LEG_INDEX, GIDX_ROUTER});
        else if (PREV_ACT_VALID && NEXT_INDEX_CONTROL == NXT_SERVICE)
            put(2, 14, {SERVICE_INDEX, GIDX_SERVICE});
        else if (PREV_ACT_VALID && NEXT_INDEX_CONTROL == NXT_VALUE)
            put(2, 14, {NEXT_INDEX_VALUE, GIDX_COMPUTED});
        else put(2, 14, {GIDX_DEF_SEL == GDEF_LPORT ? {5'h00, LOGICAL_PORT} :
            GIDX_DEF_SEL == GDEF_MASQ ? {5'h00, MASQ_PORT} : 12'h000, GIDX_DEFAULT});
        if (KEY_PAYLOAD) begin
            st = FRAME_IS_ETH ? 8'h0e + 8'h04 * TAG_COUNT : {1'b0, FRAME_PTR};
            for (int i = 0; i < 64; i++) put(16 + 8 * i, 8, FRAME_HEAD[8 * ((st + i) % 128) +: 8]);
        end else begin
            if ((PROC_INJECTED && PROC_MASK_EN) ||
                ((SRC_FLAGS[SRC_VD0] || SRC_FLAGS[SRC_VD1]) && VD_MASK_EN))
                put(16, 67, {44'h0, PERIODIC_INJ, PIPELINE_ACTION, PIPELINE_POINT, SRC_PORT,
                    SRC_FLAGS, MASK_PROC_VD});
            else if (MASQ_MASK_EN && PIPELINE_ACTION == ACT_MASQ_INJ)
                put(16, 67, {65'h1 << MASQ_PORT, MASK_MASQ});
            else if (LOOPED) put(16, 67, {65'h1 << LOOP_PORT, MASK_LOOPBACK});
            else put(16, 67, {65'h1 << PHYS_PORT, MASK_DEFAULT});
            put(83, 5, {TAG_COUNT == 2'h3 ? 3'h7 : TAG_COUNT == 2'h2 ? 3'h3 :
                {2'h0, TAG_COUNT == 2'h1}, &DMAC, DMAC[MAC_MC_BIT]});
            for (int i = 0; i < 3; i++) put(88 + 19 * i, 19, i < TAG_COUNT ?
                {tci(TAG_TCIS[16 * i +: 16]), tpc(TAG_TPIDS[16 * i +: 16])} : 19'h0);
            t0 = USE_CL_OUTER_TAG ? CL_TCI : TAG_COUNT == 2'h0 ? 16'h0000 : TAG_TCIS[15:0];
            put(91, 16, tci(t0));
            put(145, 96, {SMAC, DMAC});
            put(241, 2, {TYPE_LEN >= OVERLOADED_TYPE_FIELD_MIN,
                ip && (is4 ? DIP[31:28] == IP4_MC_PFX : DIP[127:120] == IP6_MC_PFX)});
            put(243, 16, TYPE_LEN < OVERLOADED_TYPE_FIELD_MIN ? (LLC_HDR == LLC_SNAP ?
                SNAP_PID[39:24] : LLC_HDR[23:8]) : ip ? (tu ? L4_DPORT_IN : {8'h00, IP_PROTO})
                : TYPE_LEN);
            put(259, 2, {is4, ip || (TYPE_LEN < OVERLOADED_TYPE_FIELD_MIN && LLC_HDR == LLC_SNAP)});
            put(261, 2, FRAG_OFFSET == 13'h0000 ? {1'b0, MORE_FRAGS} :
                FRAG_OFFSET > FRAG_OFFSET_THRES ? 2'h3 : 2'h2);
            put(263, 2, {is4 && IP_HDR_LEN > IHL_MIN, L4_LEN < MIN_L4_LEN});
            put(265, 6, USE_CL_DSCP ? CL_DSCP : FRAME_DSCP);
            // addresses, transport flags and source port
            if (is6) put(271, 256, {SIP, DIP});
            if (is4) put(271, 32, DIP[31:0]);
            if (is4) put(399, 32, SIP[31:0]);
            put(527, 2, {ip && IP_PROTO == PROTO_TCP, tu || OAM_FRAME});
            put(529, 16, OAM_FRAME ? (16'h0001 << OAM_LEVEL) - 16'h0001 : SOURCE_PORT_FIELD_IN);
            put(545, 8, RANGE_MASK);
        end
        exp_q.push_back(wckb_note_t'{e, c});
    endtask

    // Run of mostly back-to-back requests
    task automatic burst();
        for (int n = 0; n < 300; n++) begin
            @(posedge MCLK);
            drive(($random(seed) & 3) != 0);
            #1;
            if (KEY_REQ) note();
            if (KEY_REQ) nreq++;
        end
        @(posedge MCLK);
        drive(1'b0);
        repeat (3) @(posedge MCLK);
        chk("consumed keys", hits, nreq);
    endtask

    // Clock at 50 MHz
    always #10 MCLK = ~MCLK;

    // Watcher: each valid key pairs with the oldest note
    always @(negedge MCLK) begin
        if (KEY_VALID === 1'b1 && exp_q.size() == 0) chk("spare key", 1, 0);
        else if (KEY_VALID === 1'b1) begin
            got = exp_q.pop_front();
            chk("key", KEY & got.c, got.e);
        end
    end

    // Hang guard
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        MCLK = 1'b0;
        RST_B <= 1'b0;
        {CUSTOM_TPID1, CUSTOM_TPID2, CUSTOM_TPID3} <= {16'h9100, 16'h9200, 16'h9300};
        drive(1'b0);
        repeat (12) @(posedge MCLK);
        RST_B <= 1'b1;
        burst();
        RST_B <= 1'b0;
        @(posedge MCLK);
        #1;
        chk("key in reset", KEY, '0);
        chk("valid in reset", KEY_VALID, 0);
        @(posedge MCLK);
        RST_B <= 1'b1;
        nreq = 0;
        burst();
        give_verdict();
    end
endmodule
`default_nettype wire
